// file: pkg/ssc_pkg.sv
/*
 * Constants, state encodings and field layout for the synthesizer serial configuration port.
 * Assumes a single 20 MHz mclk domain; all users import ssc_pkg::*.
 */
package ssc_pkg;
    localparam int LOAD_W = 26;
    localparam int HOLD_W = 24;
    localparam int CODE_W = 7;

    // Hold register addresses
    localparam logic [1:0] ADDR_OPMODE = 2'h0;
    localparam logic [1:0] ADDR_CAL    = 2'h1;
    localparam logic [1:0] ADDR_FREQ1  = 2'h2;
    localparam logic [1:0] ADDR_FREQ2  = 2'h3;

    // Operation mode field positions
    localparam int F_PUMP_LO  = 2;
    localparam int F_DELAY_LO = 5;
    localparam int F_POL      = 7;
    localparam int F_HIZ      = 8;
    localparam int F_MOD_SUP  = 10;
    localparam int F_CNT_SUP  = 11;
    localparam int F_SUP_EN   = 12;
    localparam int F_BW_LO    = 13;
    localparam int F_DIAG_LO  = 15;
    localparam int F_BIAS_LO  = 21;
    localparam int F_PRESC    = 23;
    // Calibration word arm bit
    localparam int F_ARM      = 20;

    // Reset values
    localparam logic [HOLD_W-1:0] HOLD_RST = 24'h000000;
    localparam logic [LOAD_W-1:0] LOAD_RST = 26'h0000000;

    // Decoded value steps
    localparam logic [10:0] PUMP_STEP_UA = 11'h0C8;
    localparam logic [4:0]  BIAS_BASE_UA = 5'h14;
    localparam logic [5:0]  BW_BASE_MHZ  = 6'h14;
    localparam logic [3:0]  DLY_NS_0     = 4'h2;
    localparam logic [3:0]  DLY_NS_1     = 4'h4;
    localparam logic [3:0]  DLY_NS_2     = 4'h7;
    localparam logic [3:0]  DLY_NS_3     = 4'h9;
    localparam logic [4:0]  SUP_OFF_DV   = 5'h00;
    localparam logic [4:0]  SUP_LOW_DV   = 5'h12;
    localparam logic [4:0]  SUP_HIGH_DV  = 5'h18;

    // Diagnostic select codes
    localparam logic [2:0] DIAG_LOCK = 3'h0;
    localparam logic [2:0] DIAG_REF  = 3'h1;
    localparam logic [2:0] DIAG_FB   = 3'h2;

    // Prescaler base moduli
    localparam logic [4:0] PRESC_SMALL = 5'h08;
    localparam logic [4:0] PRESC_LARGE = 5'h10;

    // Coarse tuning start code and first bit
    localparam logic [CODE_W-1:0] CODE_MID  = 7'h40;
    localparam logic [2:0]        BIT_FIRST = 3'h6;

    typedef enum logic [1:0] {
        TUNE_IDLE = 2'b00,
        TUNE_RUN  = 2'b01,
        TUNE_DONE = 2'b11
    } ssc_tune_t;
endpackage : ssc_pkg

// file: hdl/ssc_config_port.sv
/*
 * Serial configuration port: load register, four hold registers, operation mode
 * decode, feedback divider and coarse oscillator tuning loop.
 * Assumes all inputs are synchronous to mclk and the serial clock is well below mclk/2.
 */
`timescale 1ns/10ps
module ssc_config_port (
    input  wire logic                           mclk,
    input  wire logic                           rst,
    input  wire logic                           ser_clk,
    input  wire logic                           ser_data,
    input  wire logic                           latch_strobe,
    input  wire logic                           vco_tick,
    input  wire logic                           modulus_ctl,
    input  wire logic                           tune_cmp_hi,
    input  wire logic                           lock_status,
    input  wire logic                           ref_div_out,
    input  wire logic                           fb_div_out,
    output logic [ssc_pkg::HOLD_W-1:0]          op_mode_word,
    output logic [ssc_pkg::HOLD_W-1:0]          cal_ctrl_word,
    output logic [ssc_pkg::HOLD_W-1:0]          freq1_word,
    output logic [ssc_pkg::HOLD_W-1:0]          freq2_word,
    output logic [10:0]                         pump_current_ua,
    output logic [3:0]                          pump_delay_ns,
    output logic                                detector_polarity,
    output logic                                pump_hiz,
    output logic [4:0]                          counter_supply_dv,
    output logic [4:0]                          modulator_supply_dv,
    output logic [5:0]                          refbuf_bandwidth_mhz,
    output logic [4:0]                          presc_bias_ua,
    output logic                                presc_large,
    output logic                                lock_pin,
    output logic                                vco_clk,
    output logic [ssc_pkg::CODE_W-1:0]          tune_code,
    output logic                                tune_busy,
    output logic                                tune_done,
    output logic                                tune_pending
);
    import ssc_pkg::*;

    typedef struct packed {
        logic                sclk_prev;
        logic                strobe_prev;
        logic [LOAD_W-1:0]   load;
        logic [HOLD_W-1:0]   op;
        logic [HOLD_W-1:0]   cal;
        logic [HOLD_W-1:0]   fq1;
        logic [HOLD_W-1:0]   fq2;
        logic [10:0]         pump_ua;
        logic [3:0]          dly_ns;
        logic [4:0]          cnt_dv;
        logic [4:0]          mod_dv;
        logic [5:0]          bw_mhz;
        logic [4:0]          bias_ua;
        logic                lock_pin;
        logic [4:0]          presc_cnt;
        logic                half;
        ssc_tune_t           tstate;
        logic [CODE_W-1:0]   code;
        logic [2:0]          bit_idx;
        logic                pending;
    } ssc_state_t;

    ssc_state_t s_q;
    ssc_state_t s_d;

    logic       sclk_rise;
    logic       strobe_fall;
    logic [1:0] word_addr;
    logic       arm_rise;
    logic [4:0] presc_mod;
    logic       presc_wrap;
    logic       vco_step;

    // Edge detection on the serial pins and word routing
    assign sclk_rise   = ser_clk & ~s_q.sclk_prev;
    assign strobe_fall = ~latch_strobe & s_q.strobe_prev;
    assign word_addr   = s_q.load[1:0];
    assign arm_rise    = strobe_fall && (word_addr == ADDR_CAL) && s_q.load[F_ARM] && !s_q.cal[F_ARM];

    // Prescaler modulus: base from mode bit, plus one when modulus control asks
    assign presc_mod  = (s_q.op[F_PRESC] ? PRESC_LARGE : PRESC_SMALL) + {4'h0, modulus_ctl};
    assign presc_wrap = vco_tick && (s_q.presc_cnt >= presc_mod - 5'h01);
    assign vco_step   = presc_wrap && !s_q.half;

    // Next-state logic
    always_comb begin
        logic [HOLD_W-1:0] w;
        w   = s_q.load[HOLD_W-1:0];
        s_d = s_q;
        s_d.sclk_prev   = ser_clk;
        s_d.strobe_prev = latch_strobe;

        // Shift in MSB first while strobe is low
        if (!latch_strobe && sclk_rise) begin
            s_d.load = {s_q.load[LOAD_W-2:0], ser_data};
        end

        // Latch into the addressed hold register on strobe fall
        if (strobe_fall) begin
            unique case (word_addr)
                ADDR_OPMODE: begin
                    s_d.op = w;
                    s_d.pump_ua = 11'(({8'h00, w[F_PUMP_LO+2:F_PUMP_LO]} + 11'h001) * PUMP_STEP_UA);
                    unique case (w[F_DELAY_LO+1:F_DELAY_LO])
                        2'h0: s_d.dly_ns = DLY_NS_0;
                        2'h1: s_d.dly_ns = DLY_NS_1;
                        2'h2: s_d.dly_ns = DLY_NS_2;
                        2'h3: s_d.dly_ns = DLY_NS_3;
                    endcase
                    if (!w[F_SUP_EN]) begin
                        s_d.cnt_dv = SUP_OFF_DV;
                        s_d.mod_dv = SUP_OFF_DV;
                    end else begin
                        s_d.cnt_dv = w[F_CNT_SUP] ? SUP_HIGH_DV : SUP_LOW_DV;
                        s_d.mod_dv = w[F_MOD_SUP] ? SUP_HIGH_DV : SUP_LOW_DV;
                    end
                    s_d.bw_mhz  = BW_BASE_MHZ + 6'({w[F_BW_LO+1:F_BW_LO], 3'h0} + {w[F_BW_LO+1:F_BW_LO], 1'b0});
                    s_d.bias_ua = BIAS_BASE_UA + {2'h0, w[F_BIAS_LO+1:F_BIAS_LO], 1'b0};
                end
                ADDR_CAL: begin
                    s_d.cal = w;
                end
                ADDR_FREQ1: begin
                    s_d.fq1     = w;
                    s_d.pending = 1'b1;
                end
                ADDR_FREQ2: begin
                    s_d.fq2     = w;
                    s_d.pending = 1'b1;
                end
            endcase
        end

        // Diagnostic pin mux; unused codes drive low
        unique case (s_q.op[F_DIAG_LO+2:F_DIAG_LO])
            DIAG_LOCK: s_d.lock_pin = lock_status;
            DIAG_REF:  s_d.lock_pin = ref_div_out;
            DIAG_FB:   s_d.lock_pin = fb_div_out;
            default:   s_d.lock_pin = 1'b0;
        endcase

        // Dual-modulus prescaler followed by a halving stage
        if (vco_tick) begin
            if (presc_wrap) begin
                s_d.presc_cnt = 5'h00;
                s_d.half      = ~s_q.half;
            end else begin
                s_d.presc_cnt = s_q.presc_cnt + 5'h01;
            end
        end

        // Coarse tuning: binary search, one bit per tuning clock rise
        unique case (s_q.tstate)
            TUNE_IDLE, TUNE_DONE: begin
                if (arm_rise) begin
                    s_d.tstate  = TUNE_RUN;
                    s_d.code    = CODE_MID;
                    s_d.bit_idx = BIT_FIRST;
                    s_d.pending = 1'b0;
                end
            end
            TUNE_RUN: begin
                if (vco_step) begin
                    if (tune_cmp_hi) begin
                        s_d.code[s_q.bit_idx] = 1'b0;
                    end
                    if (s_q.bit_idx == 3'h0) begin
                        s_d.tstate = TUNE_DONE;
                    end else begin
                        s_d.code[s_q.bit_idx - 3'h1] = 1'b1;
                        s_d.bit_idx = s_q.bit_idx - 3'h1;
                    end
                end
            end
            default: begin
                s_d.tstate = TUNE_IDLE;
            end
        endcase
    end

    // State register; pending starts high so power-on needs a tuning run
    always_ff @(posedge mclk) begin
        if (rst) begin
            s_q           <= '0;
            s_q.load      <= LOAD_RST;
            s_q.op        <= HOLD_RST;
            s_q.cal       <= HOLD_RST;
            s_q.fq1       <= HOLD_RST;
            s_q.fq2       <= HOLD_RST;
            s_q.tstate    <= TUNE_IDLE;
            s_q.code      <= CODE_MID;
            s_q.pending   <= 1'b1;
            s_q.pump_ua   <= PUMP_STEP_UA;
            s_q.dly_ns    <= DLY_NS_0;
            s_q.bw_mhz    <= BW_BASE_MHZ;
            s_q.bias_ua   <= BIAS_BASE_UA;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from state flops; tune_busy and tune_done are decoded from tstate
    assign op_mode_word         = s_q.op;
    assign cal_ctrl_word        = s_q.cal;
    assign freq1_word           = s_q.fq1;
    assign freq2_word           = s_q.fq2;
    assign pump_current_ua      = s_q.pump_ua;
    assign pump_delay_ns        = s_q.dly_ns;
    assign detector_polarity    = s_q.op[F_POL];
    assign pump_hiz             = s_q.op[F_HIZ];
    assign counter_supply_dv    = s_q.cnt_dv;
    assign modulator_supply_dv  = s_q.mod_dv;
    assign refbuf_bandwidth_mhz = s_q.bw_mhz;
    assign presc_bias_ua        = s_q.bias_ua;
    assign presc_large          = s_q.op[F_PRESC];
    assign lock_pin             = s_q.lock_pin;
    assign vco_clk              = s_q.half;
    assign tune_code            = s_q.code;
    assign tune_busy            = (s_q.tstate == TUNE_RUN);
    assign tune_done            = (s_q.tstate == TUNE_DONE);
    assign tune_pending         = s_q.pending;
endmodule : ssc_config_port

// file: tb/ssc_chk_assertions.sv
/* Checker for the serial configuration port.
   Bound to ssc_config_port; one mclk domain, rst synchronous. */
`timescale 1ns/10ps
module ssc_chk
    import ssc_pkg::*;
(
    input wire logic mclk, rst, latch_strobe, lock_status, ref_div_out, fb_div_out,
    input wire logic [ssc_pkg::HOLD_W-1:0] op_mode_word, cal_ctrl_word, freq1_word,
    input wire logic [10:0] pump_current_ua,
    input wire logic [3:0] pump_delay_ns,
    input wire logic [4:0] counter_supply_dv, modulator_supply_dv, presc_bias_ua,
    input wire logic [5:0] refbuf_bandwidth_mhz,
    input wire logic detector_polarity, pump_hiz, presc_large, lock_pin,
    input wire logic tune_busy, tune_done, tune_pending,
    input wire logic [ssc_pkg::CODE_W-1:0] tune_code
);
    // Aliases and expected diagnostic level
    wire [23:0] o = op_mode_word;
    wire [2:0] s = o[17:15];
    wire dg = s == DIAG_LOCK ? lock_status : s == DIAG_REF ? ref_div_out : s == DIAG_FB ? fb_div_out : 1'b0;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_pump; pump_current_ua == (11'(o[4:2]) + 11'h001) * PUMP_STEP_UA; endproperty
    a_pump: assert property (p_pump) else $error("pump current");
    property p_dly; pump_delay_ns == (o[6] ? (o[5] ? 4'h9 : 4'h7) : (o[5] ? 4'h4 : 4'h2)); endproperty
    a_dly: assert property (p_dly) else $error("pump delay");
    property p_polhiz; detector_polarity == o[F_POL] && pump_hiz == o[F_HIZ]; endproperty
    a_polhiz: assert property (p_polhiz) else $error("polarity or hiz");
    property p_sup; counter_supply_dv == (o[12] ? (o[11] ? 5'h18 : 5'h12) : 5'h00)
        && modulator_supply_dv == (o[12] ? (o[10] ? 5'h18 : 5'h12) : 5'h00); endproperty
    a_sup: assert property (p_sup) else $error("supply select");
    property p_bw; refbuf_bandwidth_mhz == 6'h14 + 6'h0A * o[14:13] && presc_bias_ua == 5'h14 + 5'h02 * o[22:21];
    endproperty
    a_bw: assert property (p_bw) else $error("bandwidth or bias");
    property p_presc; presc_large == o[F_PRESC]; endproperty
    a_presc: assert property (p_presc) else $error("prescaler mode");
    property p_diag; !$past(rst) |-> lock_pin == $past(dg); endproperty
    a_diag: assert property (p_diag) else $error("lock pin mux");
    property p_latch; $changed(o) |-> $past(latch_strobe, 2) && !$past(latch_strobe) && o[1:0] == ADDR_OPMODE;
    endproperty
    a_latch: assert property (p_latch) else $error("mode latch");
    property p_route; $changed(freq1_word) |-> freq1_word[1:0] == ADDR_FREQ1 && $stable(o) && tune_pending;
    endproperty
    a_route: assert property (p_route) else $error("freq routing");
    property p_quiet; $changed(o) |-> $stable(tune_pending) && $stable(freq1_word) && $stable(cal_ctrl_word);
    endproperty
    a_quiet: assert property (p_quiet) else $error("mode write disturbs");
    property p_arm; $rose(tune_busy) |-> cal_ctrl_word[F_ARM] && !$past(cal_ctrl_word[F_ARM])
        && tune_code == CODE_MID && !tune_pending; endproperty
    a_arm: assert property (p_arm) else $error("tuning start");
    property p_code; $rose(tune_busy) |-> ##[7:1000] $rose(tune_done); endproperty
    a_code: assert property (p_code) else $error("tuning length");
    // Main scenarios reached
    c_tune: cover property ($rose(tune_done));
    c_freq: cover property ($changed(freq1_word));
    c_ref: cover property (s == DIAG_REF ##1 lock_pin);
endmodule : ssc_chk
bind ssc_config_port ssc_chk u_chk (.*);

// file: tb/ssc_host.sv
/* Host model of the three-wire programming link.
   Driven by the bench through send; samples nothing. */
`timescale 1ns/10ps
module ssc_host (
    input  wire logic mclk,
    output logic      ser_clk,
    output logic      ser_data,
    output logic      latch_strobe
);
    // Idle link: clock parked low, strobe low
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        latch_strobe = 1'b0;
    end
    // Shift a word MSB first, then pulse strobe to latch it
    task automatic send(input logic [25:0] w);
        for (int i = 25; i >= 0; i--) begin
            @(posedge mclk) ser_data <= w[i];
            @(posedge mclk) ser_clk <= 1'b1;
            @(posedge mclk);
            @(posedge mclk) ser_clk <= 1'b0;
            @(posedge mclk) ser_data <= ~w[i]; // Stale bit inverted
        end
        @(posedge mclk) latch_strobe <= 1'b1;
        @(posedge mclk);
        @(posedge mclk) latch_strobe <= 1'b0;
        @(posedge mclk);
    endtask : send
endmodule : ssc_host

// file: tb/ssc_config_port_tb_top.sv
/* Testbench for the serial configuration port.
   Host model drives the link; checker is bound to the design. */
`timescale 1ns/10ps
module ssc_config_port_tb_top;
    import ssc_pkg::*;
    logic mclk, rst, ser_clk, ser_data, latch_strobe, tune_cmp_hi, lg, modulus_ctl;
    logic detector_polarity, pump_hiz, presc_large, lock_pin, vco_clk, tune_busy, tune_done, tune_pending;
    logic [HOLD_W-1:0] op_mode_word, cal_ctrl_word, freq1_word, freq2_word;
    logic [10:0] pump_current_ua;
    logic [3:0] pump_delay_ns;
    logic [4:0] counter_supply_dv, modulator_supply_dv, presc_bias_ua;
    logic [5:0] refbuf_bandwidth_mhz;
    logic [CODE_W-1:0] tune_code;
    logic [7:0] cnt, c;
    logic [2:0] d;
    logic [25:0] w;
    int failures, checks, hl;
    wire vco_tick = 1'b1;
    wire lock_status = cnt[1];
    wire ref_div_out = cnt[0];
    wire fb_div_out = ~cnt[1];
    ssc_config_port dut (
        .mclk                 (mclk),
        .rst                  (rst),
        .ser_clk              (ser_clk),
        .ser_data             (ser_data),
        .latch_strobe         (latch_strobe),
        .vco_tick             (vco_tick),
        .modulus_ctl          (modulus_ctl),
        .tune_cmp_hi          (tune_cmp_hi),
        .lock_status          (lock_status),
        .ref_div_out          (ref_div_out),
        .fb_div_out           (fb_div_out),
        .op_mode_word         (op_mode_word),
        .cal_ctrl_word        (cal_ctrl_word),
        .freq1_word           (freq1_word),
        .freq2_word           (freq2_word),
        .pump_current_ua      (pump_current_ua),
        .pump_delay_ns        (pump_delay_ns),
        .detector_polarity    (detector_polarity),
        .pump_hiz             (pump_hiz),
        .counter_supply_dv    (counter_supply_dv),
        .modulator_supply_dv  (modulator_supply_dv),
        .refbuf_bandwidth_mhz (refbuf_bandwidth_mhz),
        .presc_bias_ua        (presc_bias_ua),
        .presc_large          (presc_large),
        .lock_pin             (lock_pin),
        .vco_clk              (vco_clk),
        .tune_code            (tune_code),
        .tune_busy            (tune_busy),
        .tune_done            (tune_done),
        .tune_pending         (tune_pending)
    );
    ssc_host host (.mclk(mclk), .ser_clk(ser_clk), .ser_data(ser_data), .latch_strobe(latch_strobe));
    // Clock and diagnostic input pattern
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) cnt <= cnt + 8'h01;
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Write one word and let the latch land
    task automatic put(input logic [25:0] v);
        host.send(v);
        @(posedge mclk);
        #1;
    endtask : put
    task automatic wait_done;
        for (int k = 0; k < 1000 && tune_done !== 1'b1; k++) @(posedge mclk);
        #1;
    endtask : wait_done
    // Length of one full high phase of the halving stage output, in mclk cycles
    task automatic half_len(output int n);
        n = 0;
        while (vco_clk !== 1'b0) begin @(posedge mclk); #1; end
        while (vco_clk !== 1'b1) begin @(posedge mclk); #1; end
        while (vco_clk === 1'b1 && n < 64) begin @(posedge mclk); #1; n++; end
    endtask : half_len
    task automatic wrap_up;
        $display("Checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    // Watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        wrap_up();
    end
    // Main sequence
    initial begin
        rst = 1'b1;
        tune_cmp_hi = 1'b0;
        modulus_ctl = 1'b0;
        cnt = 8'h00;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        chk("pump", 11'h0C8, pump_current_ua);
        chk("dly", 4'h2, pump_delay_ns);
        chk("pend", 1'b1, tune_pending);
        // Every code of every mode field
        for (int i = 0; i < 8; i++) begin
            d = i[2:0];
            w = {2'h0, d[2], d[2:1], 3'h0, d, d[1:0], d, 1'b0, d[1], d[0], d[1:0], d, ADDR_OPMODE};
            put(w);
            c = cnt - 8'h01;
            lg = d == 3'h0 ? c[1] : d == 3'h1 ? c[0] : d == 3'h2 ? ~c[1] : 1'b0;
            chk("op", w[23:0], op_mode_word);
            chk("pump", 11'(d) * 11'h0C8 + 11'h0C8, pump_current_ua);
            chk("dly", d[1] ? (d[0] ? 4'h9 : 4'h7) : (d[0] ? 4'h4 : 4'h2), pump_delay_ns);
            chk("pol", d[0], detector_polarity);
            chk("hiz", d[1], pump_hiz);
            chk("csup", d[2] ? (d[1] ? 5'h18 : 5'h12) : 5'h00, counter_supply_dv);
            chk("msup", d[2] ? (d[0] ? 5'h18 : 5'h12) : 5'h00, modulator_supply_dv);
            chk("bw", 6'h14 + 6'h0A * d[1:0], refbuf_bandwidth_mhz);
            chk("bias", 5'h14 + 5'h02 * d[2:1], presc_bias_ua);
            chk("presc", d[2], presc_large);
            chk("lock", lg, lock_pin);
        end
        // Halving stage after the large prescaler, without and with the modulus bump
        half_len(hl);
        chk("vclk16", 24'h10, 24'(hl));
        @(posedge mclk) modulus_ctl <= 1'b1;
        half_len(hl);
        chk("vclk17", 24'h11, 24'(hl));
        // Frequency words route by address
        put({2'h0, 22'h0ABCD, ADDR_FREQ1});
        chk("f1", {22'h0ABCD, ADDR_FREQ1}, freq1_word);
        chk("opkeep", w[23:0], op_mode_word);
        chk("pend", 1'b1, tune_pending);
        put({2'h0, 22'h01234, ADDR_FREQ2});
        chk("f2", {22'h01234, ADDR_FREQ2}, freq2_word);
        // Arm low then high; comparator low gives all ones
        put({2'h0, 22'h0, ADDR_CAL});
        chk("busy", 1'b0, tune_busy);
        put({2'h0, 22'h040000, ADDR_CAL});
        chk("cal", 24'h100001, cal_ctrl_word);
        chk("busy", 1'b1, tune_busy);
        chk("pend", 1'b0, tune_pending);
        put(w);
        chk("busy", 1'b1, tune_busy);
        chk("pend", 1'b0, tune_pending);
        wait_done();
        chk("done", 1'b1, tune_done);
        chk("code", 7'h7F, tune_code);
        put({2'h0, 22'h040000, ADDR_CAL});
        chk("rearm", 1'b0, tune_busy);
        // New frequency, fresh arm; comparator high gives zero
        @(posedge mclk) tune_cmp_hi <= 1'b1;
        put({2'h0, 22'h0ABCE, ADDR_FREQ1});
        chk("pend", 1'b1, tune_pending);
        put({2'h0, 22'h0, ADDR_CAL});
        put({2'h0, 22'h040000, ADDR_CAL});
        wait_done();
        chk("code", 7'h00, tune_code);
        wrap_up();
    end
endmodule : ssc_config_port_tb_top
